// ==== design/mdc_mode_regs.sv ====
// Purpose: mode register set decode, storage and setting decode
// Assumes: command pins sampled on the link clock i_ck
// Notes: clock enable freezes the core domain only
`timescale 1ns/10ps
`include "mdc_defs.svh"

module mdc_mode_regs (
  // core clock and reset
  input wire logic i_core_clk,
  input wire logic i_rst_b,
  input wire logic i_clk_en,
  // command bus on link clock
  input wire logic i_ck,
  input wire logic i_cs_b,
  input wire logic i_ras_b,
  input wire logic i_cas_b,
  input wire logic i_we_b,
  input wire logic [2:0] i_ba,
  input wire logic [15:0] i_addr,
  // core status
  input wire logic i_power_down,
  input wire logic i_self_refresh,
  input wire logic [4:0] i_cas_latency,
  // stored registers
  output mdc_pkg::mdc_mr_t o_mr0,
  output mdc_pkg::mdc_mr_t o_mr1,
  output mdc_pkg::mdc_mr_t o_mr2,
  output mdc_pkg::mdc_mr_t o_mr3,
  // dll and power-down
  output logic o_dll_run,
  output logic o_dll_locked,
  output logic o_cmd_ready,
  // decoded settings
  output logic [1:0] o_drive_sel,
  output logic [2:0] o_nom_term,
  output logic [1:0] o_wr_term,
  output logic o_use_wr_term,
  output logic o_write_lvl,
  output logic o_out_disable,
  output logic [4:0] o_additive_latency,
  output logic o_al_reserved,
  output logic [5:0] o_read_latency,
  output logic [5:0] o_write_latency,
  output logic [2:0] o_partial_array_self_refresh,
  output logic o_cal_pattern_en,
  output logic [1:0] o_cal_loc
);
  import mdc_pkg::*;

  localparam int SLOW_CYC = `MDC_SLOW_CYC;
  localparam int FAST_CYC = `MDC_FAST_CYC;
  localparam int LOCK_CYC = `MDC_DLL_LOCK_CYC;

  // link domain: decode and hold
  logic [15:0] lmr [4];
  logic ltog;
  logic [1:0] lsel;
  logic mrs;
  assign mrs = ~i_cs_b & ~i_ras_b & ~i_cas_b & ~i_we_b & ~i_ba[2];

  // registers live on the link clock so no command is missed
  always_ff @(posedge i_ck or negedge i_rst_b) begin
    if (!i_rst_b) begin
      for (int i = 0; i < 4; i++) begin
        lmr[i] <= `MDC_MR_RST;
      end
      ltog <= 1'b0;
      lsel <= 2'h0;
    end else if (mrs) begin
      lmr[i_ba[1:0]] <= i_addr;
      lsel <= i_ba[1:0];
      ltog <= ~ltog;
    end
  end

  // core domain: toggle crossing
  logic [2:0] tsync;
  logic tseen;
  logic upd;
  always_ff @(posedge i_core_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      tsync <= 3'h0;
    end else if (i_clk_en) begin
      tsync <= {tsync[1:0], ltog};
    end
  end
  // link data is stable long before the toggle settles
  assign upd = (tsync[1] == tsync[2]) && (tsync[2] != tseen);

  logic [15:0] lock_cnt;
  always_ff @(posedge i_core_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      tseen <= 1'b0;
      o_mr0 <= `MDC_MR_RST;
      o_mr1 <= `MDC_MR_RST;
      o_mr2 <= `MDC_MR_RST;
      o_mr3 <= `MDC_MR_RST;
    end else if (i_clk_en) begin
      if (upd) begin
        tseen <= tsync[2];
        // only the addressed register: a stale dll reset must not replay
        unique case ({1'b0, lsel})
          `MDC_BA_MR0: o_mr0 <= lmr[0];
          `MDC_BA_MR1: o_mr1 <= lmr[1];
          `MDC_BA_MR2: o_mr2 <= lmr[2];
          `MDC_BA_MR3: o_mr3 <= lmr[3];
        endcase
      end else if (o_mr0[`MDC_MR0_DLL_RST]) begin
        // dll reset bit clears itself once applied
        o_mr0[`MDC_MR0_DLL_RST] <= 1'b0;
      end
    end
  end

  // dll lock timer
  logic dll_en;
  assign dll_en = ~o_mr1[`MDC_MR1_DLL_OFF];
  always_ff @(posedge i_core_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      lock_cnt <= 16'h0000;
    end else if (i_clk_en) begin
      if (o_mr0[`MDC_MR0_DLL_RST] && dll_en) begin
        lock_cnt <= 16'(LOCK_CYC);
      end else if (lock_cnt != 16'h0000) begin
        lock_cnt <= lock_cnt - 16'h0001;
      end
    end
  end

  // power-down exit sequencing
  mdc_pd_e pd_st;
  mdc_pd_e next_pd_st;
  logic [7:0] exit_cnt;
  logic slow_exit;
  assign slow_exit = ~o_mr0[`MDC_MR0_PPD];

  always_comb begin
    next_pd_st = pd_st;
    unique case (pd_st)
      MDC_PD_IDLE: begin
        if (i_power_down) begin
          next_pd_st = MDC_PD_SLEEP;
        end
      end
      MDC_PD_SLEEP: begin
        if (!i_power_down) begin
          next_pd_st = MDC_PD_EXIT;
        end
      end
      MDC_PD_EXIT: begin
        if (exit_cnt == 8'h01) begin
          next_pd_st = MDC_PD_IDLE;
        end
      end
      default: next_pd_st = MDC_PD_IDLE;
    endcase
  end

  always_ff @(posedge i_core_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      pd_st <= MDC_PD_IDLE;
      exit_cnt <= 8'h00;
    end else if (i_clk_en) begin
      pd_st <= next_pd_st;
      if (pd_st == MDC_PD_SLEEP && !i_power_down) begin
        exit_cnt <= slow_exit ? 8'(SLOW_CYC) : 8'(FAST_CYC);
      end else if (exit_cnt != 8'h00) begin
        exit_cnt <= exit_cnt - 8'h01;
      end
    end
  end

  // decoded settings, registered
  logic [4:0] al;
  always_comb begin
    unique case (o_mr1[`MDC_MR1_AL_HI:`MDC_MR1_AL_LO])
      `MDC_AL_M1: al = i_cas_latency - 5'h01;
      `MDC_AL_M2: al = i_cas_latency - 5'h02;
      default: al = 5'h00;
    endcase
  end

  logic [2:0] nom;
  logic [5:0] cas_write_latency;
  assign nom = {o_mr1[`MDC_MR1_NT_2], o_mr1[`MDC_MR1_NT_1],
    o_mr1[`MDC_MR1_NT_0]};
  assign cas_write_latency = `MDC_CWL_BASE +
    6'(o_mr2[`MDC_MR2_CWL_HI:`MDC_MR2_CWL_LO]);

  always_ff @(posedge i_core_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      o_dll_run <= 1'b0;
      o_dll_locked <= 1'b0;
      o_cmd_ready <= 1'b0;
      o_drive_sel <= 2'h0;
      o_nom_term <= 3'h0;
      o_wr_term <= 2'h0;
      o_use_wr_term <= 1'b0;
      o_write_lvl <= 1'b0;
      o_out_disable <= 1'b0;
      o_additive_latency <= 5'h00;
      o_al_reserved <= 1'b0;
      o_read_latency <= 6'h00;
      o_write_latency <= 6'h00;
      o_partial_array_self_refresh <= 3'h0;
      o_cal_pattern_en <= 1'b0;
      o_cal_loc <= 2'h0;
    end else if (i_clk_en) begin
      o_dll_run <= dll_en && !i_self_refresh &&
        !(pd_st == MDC_PD_SLEEP && slow_exit);
      o_dll_locked <= dll_en && lock_cnt == 16'h0000 &&
        !o_mr0[`MDC_MR0_DLL_RST];
      o_cmd_ready <= (next_pd_st == MDC_PD_IDLE);
      o_drive_sel <= {o_mr1[`MDC_MR1_DRV_HI],
        o_mr1[`MDC_MR1_DRV_LO]};
      o_nom_term <= nom;
      o_wr_term <= o_mr2[`MDC_MR2_WT_HI:`MDC_MR2_WT_LO];
      // write leveling keeps only nominal termination
      o_use_wr_term <= !o_mr1[`MDC_MR1_WLVL] &&
        o_mr2[`MDC_MR2_WT_HI:`MDC_MR2_WT_LO] != 2'h0;
      o_write_lvl <= o_mr1[`MDC_MR1_WLVL];
      o_out_disable <= o_mr1[`MDC_MR1_QOFF];
      o_additive_latency <= al;
      o_al_reserved <= o_mr1[`MDC_MR1_AL_HI:`MDC_MR1_AL_LO] ==
        `MDC_AL_RSV;
      o_read_latency <= 6'(al) + 6'(i_cas_latency);
      o_write_latency <= 6'(al) + cas_write_latency;
      o_partial_array_self_refresh <= o_mr2[`MDC_MR2_PARTIAL_ARRAY_SELF_REFRESH_HI:0];
      o_cal_pattern_en <= o_mr3[`MDC_MR3_CAL];
      o_cal_loc <= o_mr3[`MDC_MR3_CAL] ? o_mr3[1:0] : 2'h0;
    end
  end

  // checks
  default clocking cb @(posedge i_core_clk); endclocking
  default disable iff (!i_rst_b);

  chk_mrs_latch_link: assert property (
    @(posedge i_ck) disable iff (!i_rst_b)
    mrs |=> lmr[$past(i_ba[1:0])] == $past(i_addr))
    else $error("mode register set not latched");
  chk_mr_decode_bank: assert property (
    @(posedge i_ck) disable iff (!i_rst_b)
    !(mrs && i_ba == `MDC_BA_MR1) |=> $stable(lmr[1]))
    else $error("register one changed without its command");
  chk_dll_self_ref: assert property (
    (i_clk_en && i_self_refresh) |=> !o_dll_run)
    else $error("dll running in self refresh");
  chk_slow_exit_wait: assert property (
    (i_clk_en && pd_st == MDC_PD_SLEEP && !i_power_down && slow_exit)
    |=> exit_cnt == 8'(SLOW_CYC))
    else $error("slow exit count wrong");
  chk_fast_exit_wait: assert property (
    (i_clk_en && pd_st == MDC_PD_SLEEP && !i_power_down && !slow_exit)
    |=> exit_cnt == 8'(FAST_CYC))
    else $error("fast exit count wrong");
  chk_drive_sel_bits: assert property (
    i_clk_en |=> o_drive_sel == {$past(o_mr1[`MDC_MR1_DRV_HI]),
    $past(o_mr1[`MDC_MR1_DRV_LO])})
    else $error("driver select mismatch");
  chk_al_read_sum: assert property (
    (i_clk_en && o_mr1[`MDC_MR1_AL_HI:`MDC_MR1_AL_LO] == `MDC_AL_M2) |=>
    o_read_latency == 6'($past(i_cas_latency)) * 6'h02 - 6'h02)
    else $error("read latency wrong for cl minus two");
  chk_cal_loc_ignored: assert property (
    (i_clk_en && !o_mr3[`MDC_MR3_CAL]) |=>
    o_cal_loc == 2'h0 && !o_cal_pattern_en)
    else $error("calibration location not ignored");
  chk_wlvl_no_wr_term: assert property (
    (i_clk_en && o_mr1[`MDC_MR1_WLVL]) |=> !o_use_wr_term)
    else $error("write termination used in write leveling");
  chk_qoff_follows: assert property (
    i_clk_en |=> o_out_disable == $past(o_mr1[`MDC_MR1_QOFF]))
    else $error("output disable mismatch");
  chk_upd_own_reg: assert property (
    (i_clk_en && upd && {1'b0, lsel} != `MDC_BA_MR3) |=> $stable(o_mr3))
    else $error("register three changed by another command");

  cov_mrs_update: cover property (upd);
  cov_pd_exit: cover property (pd_st == MDC_PD_EXIT ##1 o_cmd_ready);
  cov_dll_lock: cover property (lock_cnt == 16'h0001 ##1 o_dll_locked);
  cov_cal_mode: cover property (o_cal_pattern_en);
endmodule

// ==== design/mdc_defs.svh ====
// Purpose: constants for the mode register configuration block
// Assumes: 100 MHz core clock
// Notes: definitions only
`ifndef MDC_DEFS_SVH
`define MDC_DEFS_SVH
// bank address codes of each mode register
`define MDC_BA_MR0 3'h0
`define MDC_BA_MR1 3'h1
`define MDC_BA_MR2 3'h2
`define MDC_BA_MR3 3'h3
// mode register zero fields
`define MDC_MR0_DLL_RST 8
`define MDC_MR0_PPD 12
// mode register one fields
`define MDC_MR1_DLL_OFF 0
`define MDC_MR1_DRV_LO 1
`define MDC_MR1_DRV_HI 5
`define MDC_MR1_AL_HI 4
`define MDC_MR1_AL_LO 3
`define MDC_MR1_NT_0 2
`define MDC_MR1_NT_1 6
`define MDC_MR1_NT_2 9
`define MDC_MR1_WLVL 7
`define MDC_MR1_QOFF 12
// mode register two fields
`define MDC_MR2_PARTIAL_ARRAY_SELF_REFRESH_HI 2
`define MDC_MR2_CWL_HI 5
`define MDC_MR2_CWL_LO 3
`define MDC_MR2_WT_HI 10
`define MDC_MR2_WT_LO 9
// mode register three fields
`define MDC_MR3_CAL 2
// additive latency codes
`define MDC_AL_OFF 2'h0
`define MDC_AL_M1 2'h1
`define MDC_AL_M2 2'h2
`define MDC_AL_RSV 2'h3
// reset value of every mode register
`define MDC_MR_RST 16'h0000
// cas write latency of code zero
`define MDC_CWL_BASE 6'h05
// timing
`define MDC_CLK_NS 10
`define MDC_SLOW_EXIT_NS 24
`define MDC_FAST_EXIT_NS 6
`define MDC_SLOW_CYC ((`MDC_SLOW_EXIT_NS+`MDC_CLK_NS-1)/`MDC_CLK_NS)
`define MDC_FAST_CYC ((`MDC_FAST_EXIT_NS+`MDC_CLK_NS-1)/`MDC_CLK_NS)
`define MDC_DLL_LOCK_CYC 512
`endif

// ==== design/mdc_pkg.sv ====
// Purpose: types for the mode register configuration block
// Assumes: nothing
// Notes: power-down exit states are one-hot
package mdc_pkg;
  typedef enum logic [2:0] {
    MDC_PD_IDLE = 3'b001,
    MDC_PD_SLEEP = 3'b010,
    MDC_PD_EXIT = 3'b100
  } mdc_pd_e;
  typedef logic [15:0] mdc_mr_t;
endpackage

// ==== tb/mdc_ctrl_model.sv ====
// Purpose: controller model issuing mode register set commands
// Assumes: pins change on the falling link clock edge
// Notes: released pins carry the inverse of the last value
`timescale 1ns/10ps
module mdc_ctrl_model (
  // link clock
  input wire logic i_ck,
  // command pins
  output logic o_cs_b,
  output logic o_ras_b,
  output logic o_cas_b,
  output logic o_we_b,
  output logic [2:0] o_ba,
  output logic [15:0] o_addr
);
  initial begin
    {o_cs_b, o_ras_b, o_cas_b, o_we_b} = 4'hf;
    o_ba = 3'h0;
    o_addr = 16'h0000;
  end
  // one set command, held across exactly one rising edge
  task automatic mrs(input logic [2:0] ba, input logic [15:0] a);
    @(negedge i_ck);
    {o_cs_b, o_ras_b, o_cas_b, o_we_b} <= 4'h0;
    o_ba <= ba;
    o_addr <= a;
    @(negedge i_ck);
    // stale values would hide a late sample
    {o_cs_b, o_ras_b, o_cas_b, o_we_b} <= 4'hf;
    o_ba <= ~ba;
    o_addr <= ~a;
  endtask
endmodule

// ==== tb/tb_mdc_mode_regs.sv ====
// Purpose: self-checking bench for the mode register block
// Assumes: core clock 10 ns, link clock 12 ns
// Notes: register values come from a fixed lfsr
`timescale 1ns/10ps
`include "mdc_defs.svh"
module tb_mdc_mode_regs;
  import mdc_pkg::*;
  logic i_core_clk = 0;
  logic i_ck = 0;
  logic i_rst_b = 0;
  logic i_clk_en = 0;
  logic i_power_down = 0;
  logic i_self_refresh = 0;
  logic [4:0] i_cas_latency = 5'h05;
  logic cs_b, ras_b, cas_b, we_b;
  logic [2:0] ba;
  logic [15:0] addr;
  mdc_mr_t mr [4];
  logic o_dll_run, o_dll_locked, o_cmd_ready, o_use_wr_term;
  logic o_write_lvl, o_out_disable, o_al_reserved, o_cal_pattern_en;
  logic [1:0] o_drive_sel, o_wr_term, o_cal_loc;
  logic [2:0] o_nom_term, o_partial_array_self_refresh;
  logic [4:0] o_additive_latency;
  logic [5:0] o_read_latency, o_write_latency;
  mdc_mr_t exp_mr [4] = '{default: 16'h0000};
  logic [15:0] rnd = 16'h0044;
  int n_errors = 0;
  int num_checks = 0;
  int n;
  int exit_n [2];
  always #5 i_core_clk = ~i_core_clk;
  initial #2.7 forever #6 i_ck = ~i_ck;
  mdc_ctrl_model ctrl (.i_ck(i_ck), .o_cs_b(cs_b), .o_ras_b(ras_b),
    .o_cas_b(cas_b), .o_we_b(we_b), .o_ba(ba), .o_addr(addr));
  mdc_mode_regs dut (.i_core_clk(i_core_clk), .i_rst_b(i_rst_b),
    .i_clk_en(i_clk_en), .i_ck(i_ck), .i_cs_b(cs_b), .i_ras_b(ras_b),
    .i_cas_b(cas_b), .i_we_b(we_b), .i_ba(ba), .i_addr(addr),
    .i_power_down(i_power_down), .i_self_refresh(i_self_refresh),
    .i_cas_latency(i_cas_latency), .o_mr0(mr[0]), .o_mr1(mr[1]),
    .o_mr2(mr[2]), .o_mr3(mr[3]), .o_dll_run(o_dll_run),
    .o_dll_locked(o_dll_locked), .o_cmd_ready(o_cmd_ready),
    .o_drive_sel(o_drive_sel), .o_nom_term(o_nom_term),
    .o_wr_term(o_wr_term), .o_use_wr_term(o_use_wr_term),
    .o_write_lvl(o_write_lvl), .o_out_disable(o_out_disable),
    .o_additive_latency(o_additive_latency),
    .o_al_reserved(o_al_reserved), .o_read_latency(o_read_latency),
    .o_write_latency(o_write_latency), .o_partial_array_self_refresh(o_partial_array_self_refresh),
    .o_cal_pattern_en(o_cal_pattern_en), .o_cal_loc(o_cal_loc));
  function automatic logic [15:0] lfsr(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction
  function automatic logic [15:0] mask(input int r);
    case (r)
      0: return 16'h1e7f; // test mode and dll reset kept clear
      1: return 16'h12ff;
      2: return 16'h06df;
      default: return 16'h0007;
    endcase
  endfunction
  task automatic test_done();
    if (n_errors == 0 && num_checks > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  task automatic check(input string what, input logic [15:0] seen, exp);
    num_checks++;
    if (seen !== exp) begin
      n_errors++;
      $display("ERROR %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic cyc(input int k);
    repeat (k) @(negedge i_core_clk);
  endtask
  // spacing covers the crossing time between set commands
  task automatic wr(input logic [2:0] b, input logic [15:0] a);
    ctrl.mrs(b, a);
    cyc(12);
  endtask
  task automatic check_decode();
    logic [15:0] m1, m2;
    logic [5:0] al;
    logic [15:0] loc;
    m1 = exp_mr[1];
    m2 = exp_mr[2];
    al = 6'h00;
    if (m1[4:3] == 2'h1) al = 6'(i_cas_latency) - 6'h01;
    if (m1[4:3] == 2'h2) al = 6'(i_cas_latency) - 6'h02;
    loc = exp_mr[3][2] ? 16'(exp_mr[3][1:0]) : 16'h0000;
    check("drive", 16'(o_drive_sel), 16'({m1[5], m1[1]}));
    check("nom", 16'(o_nom_term), 16'({m1[9], m1[6], m1[2]}));
    check("wlvl", 16'(o_write_lvl), 16'(m1[7]));
    check("qoff", 16'(o_out_disable), 16'(m1[12]));
    check("alrsv", 16'(o_al_reserved), 16'(m1[4:3] == 2'h3));
    if (m1[4:3] != 2'h3) begin
      check("al", 16'(o_additive_latency), 16'(al));
      check("rl", 16'(o_read_latency), 16'(al + i_cas_latency));
      check("wl", 16'(o_write_latency),
        16'(al + `MDC_CWL_BASE + m2[5:3]));
    end
    check("wt", 16'(o_wr_term), 16'(m2[10:9]));
    check("usewt", 16'(o_use_wr_term),
      16'(m2[10:9] != 2'h0 && !m1[7]));
    check("partial_array_self_refresh", 16'(o_partial_array_self_refresh), 16'(m2[2:0]));
    check("cal", 16'(o_cal_pattern_en), 16'(exp_mr[3][2]));
    check("loc", 16'(o_cal_loc), loc);
  endtask
  initial begin
    #500000;
    n_errors++;
    test_done();
  end
  initial begin
    cyc(12);
    i_rst_b = 1;
    i_clk_en = 1;
    cyc(2);
    for (int r = 0; r < 4; r++) check("mr_rst", mr[r], 16'h0000);
    // every additive code appears twice
    for (int i = 0; i < 8; i++) begin
      i_cas_latency = 5'(6 + i);
      for (int r = 0; r < 4; r++) begin
        rnd = lfsr(rnd);
        exp_mr[r] = rnd & mask(r);
        if (r == 1) exp_mr[1][4:3] = 2'(i);
        // dll off: nominal termination must be off as well
        if (r == 1 && exp_mr[1][0]) begin
          exp_mr[1][9] = 1'b0;
          exp_mr[1][6] = 1'b0;
          exp_mr[1][2] = 1'b0;
        end
        // leveling with outputs on would restrict the nominal code
        if (r == 1 && exp_mr[1][7]) exp_mr[1][12] = 1'b1;
        // dll off: dynamic write termination must be off as well
        if (r == 2 && exp_mr[1][0]) exp_mr[2][10:9] = 2'h0;
        wr(3'(r), exp_mr[r]);
        check("mr", mr[r], exp_mr[r]);
      end
      check_decode();
    end
    wr(3'h1, 16'h0000);
    ctrl.mrs(3'h0, 16'h0100); // clock enable stays high
    n = 0;
    while (o_dll_locked === 1'b1 && n < 20) begin
      cyc(1);
      n++;
    end
    if (n == 20) begin
      n_errors++;
      test_done();
    end
    n = 0;
    while (o_dll_locked !== 1'b1 && n < 2000) begin
      cyc(1);
      n++;
    end
    if (n == 2000) begin
      n_errors++;
      test_done();
    end
    check("lock", 16'(n >= `MDC_DLL_LOCK_CYC), 16'h0001);
    check("lock_max", 16'(n < `MDC_DLL_LOCK_CYC + 16), 16'h0001);
    check("dll_rst", mr[0], 16'h0000);
    i_self_refresh = 1;
    cyc(3);
    check("dll_sr", 16'(o_dll_run), 16'h0000);
    i_self_refresh = 0;
    cyc(3);
    check("dll_srx", 16'(o_dll_run), 16'h0001);
    for (int f = 0; f < 2; f++) begin
      wr(3'h0, {3'h0, f[0], 12'h000});
      i_power_down = 1;
      cyc(3);
      check("pd_rdy", 16'(o_cmd_ready), 16'h0000);
      check("pd_dll", 16'(o_dll_run), 16'(f[0]));
      i_power_down = 0;
      n = 0;
      while (o_cmd_ready !== 1'b1 && n < 50) begin
        cyc(1);
        n++;
      end
      if (n == 50) begin
        n_errors++;
        test_done();
      end
      exit_n[f] = n;
    end
    check("exit", 16'(exit_n[0] - exit_n[1]),
      16'(`MDC_SLOW_CYC - `MDC_FAST_CYC));
    // frozen core must not lose a command taken meanwhile
    i_clk_en = 0;
    ctrl.mrs(3'h3, 16'h0004);
    cyc(12);
    check("frz", mr[3], exp_mr[3]);
    i_clk_en = 1;
    cyc(12);
    check("frz_upd", mr[3], 16'h0004);
    // mid-run reset clears both domains
    i_rst_b = 0;
    cyc(3);
    check("mr_rst2", mr[3], 16'h0000);
    check("cal_rst", 16'(o_cal_pattern_en), 16'h0000);
    i_rst_b = 1;
    cyc(12);
    check("mr_keep", mr[3], 16'h0000);
    test_done();
  end
endmodule
